/* logic/abou_bitops.sv */
// Combinational accumulator transforms: bit sum, shifts, rotates, encode, decode
`timescale 1ns/10ps
module abou_bitops
    import abou_pkg::*;
(
    // Operation and operands
    input  wire abou_op_t    op_in,
    input  wire logic [31:0] acc_in,
    input  wire logic [5:0]  count_in,
    // Results
    output logic      [31:0] result_out,
    output logic             error_out
);

    // Number of ones in a word
    function automatic logic [31:0] abou_ones(input logic [31:0] v);
        logic [31:0] n;
        n = 32'h0000_0000;
        for (int i = 0; i < ABOU_ACC_W; i++)
        begin
            n = n + {31'h0000_0000, v[i]};
        end
        return n;
    endfunction

    // Index of the lowest set bit, zero when none is set
    function automatic logic [31:0] abou_low_index(input logic [31:0] v);
        logic [31:0] idx;
        idx = 32'h0000_0000;
        for (int i = ABOU_ACC_W - 1; i >= 0; i--)
        begin
            if (v[i])
            begin
                idx = 32'(i);
            end
        end
        return idx;
    endfunction

    // Divide by 32 until below 32, then set that one bit only
    function automatic logic [31:0] abou_one_hot(input logic [31:0] v);
        logic [31:0] r;
        r = v;
        for (int i = 0; i < ABOU_DEC_STEPS; i++)
        begin
            if (r >= ABOU_DEC_LIMIT)
            begin
                r = r >> ABOU_DEC_DIV_SH;
            end
        end
        return 32'h0000_0001 << r[4:0];
    endfunction

    logic [4:0] rot_amt;
    logic [5:0] rot_back;

    // Rotate by 32 equals rotate by 0, so only the low five bits matter
    assign rot_amt  = count_in[4:0];
    assign rot_back = ABOU_CNT_MAX - {1'b0, rot_amt};

    // Result selection
    always_comb
    begin
        result_out = acc_in;
        error_out  = 1'b0;
        case (op_in)
            bit_sum_op:
            begin
                result_out = abou_ones(acc_in);
            end
            shift_left_op:
            begin
                // Counts of 32 or more leave nothing behind
                result_out = (count_in >= ABOU_CNT_MAX) ? 32'h0000_0000 : acc_in << count_in;
            end
            shift_right_op:
            begin
                result_out = (count_in >= ABOU_CNT_MAX) ? 32'h0000_0000 : acc_in >> count_in;
            end
            rotate_left_op:
            begin
                result_out = (acc_in << rot_amt) | (acc_in >> rot_back);
            end
            rotate_right_op:
            begin
                result_out = (acc_in >> rot_amt) | (acc_in << rot_back);
            end
            encode_op:
            begin
                result_out = abou_low_index(acc_in);
                error_out  = (abou_ones(acc_in) != 32'h0000_0001);
            end
            decode_op:
            begin
                result_out = abou_one_hot(acc_in);
            end
            default:
            begin
                result_out = acc_in;
                error_out  = 1'b0;
            end
        endcase
    end

endmodule

/* logic/abou_pkg.sv */
// Shared constants and operation codes for the accumulator bit-operation unit
package abou_pkg;

    // Datapath and memory geometry
    localparam int ABOU_ACC_W   = 32;
    localparam int ABOU_MEM_W   = 16;
    localparam int ABOU_ADDR_W  = 6;
    localparam int ABOU_MEM_DEP = 64;
    localparam int ABOU_CNT_W   = 6;

    // Values after reset
    localparam logic [31:0] ABOU_ACC_RST  = 32'h0000_0000;
    localparam logic [15:0] ABOU_RDAT_RST = 16'h0000;
    localparam logic        ABOU_FLAG_RST = 1'b0;

    // Counts and fixed figures
    localparam logic [5:0]  ABOU_CNT_MAX   = 6'h20;        // Largest shift or rotate count
    localparam logic [15:0] ABOU_MEM_ONE   = 16'h0001;     // Step of increment and decrement
    localparam logic [31:0] ABOU_DEC_LIMIT = 32'h0000_0020; // Decode reduces values at or above this
    localparam int          ABOU_DEC_DIV_SH = 5;           // Divide by 32 is a 5-place shift
    localparam int          ABOU_DEC_STEPS  = 7;           // Enough divisions for any 32-bit value

    // Operation codes issued by the sequencer
    typedef logic [3:0] abou_op_t;
    localparam abou_op_t nop_op                = 4'h0;
    localparam abou_op_t load_acc_op           = 4'h1;
    localparam abou_op_t mem_write_op          = 4'h2;
    localparam abou_op_t mem_read_op           = 4'h3;
    localparam abou_op_t binary_increment_op   = 4'h4;
    localparam abou_op_t binary_decrement_op   = 4'h5;
    localparam abou_op_t bit_sum_op            = 4'h6;
    localparam abou_op_t shift_left_op         = 4'h7;
    localparam abou_op_t shift_right_op        = 4'h8;
    localparam abou_op_t rotate_left_op        = 4'h9;
    localparam abou_op_t rotate_right_op       = 4'ha;
    localparam abou_op_t encode_op             = 4'hb;
    localparam abou_op_t decode_op             = 4'hc;

endpackage

/* logic/abou_unit.sv */
// Accumulator bit-operation unit: word memory, accumulator, zero and operand-error flags
//
// Overview of operation
// - Increment adds one to memory word, writes back
// - Decrement subtracts one from memory word, writes back
// - Zero increment or decrement result sets zero flag
// - Flags hold until next operation affecting them
// - Bit sum replaces accumulator with ones count
// - Shift left by 1 to 32, zero fill
// - Shift right by 1 to 32, zero fill
// - Rotate left by 1 to 32, circular
// - Rotate right by 1 to 32, circular
// - Encode writes set bit index to accumulator
// - Encode of zero or one gives zero
// - Several bits set: lowest encoded, error set
// - Encode of zero accumulator sets error flag
// - Decode sets bit numbered by 5-bit value
// - Decode divides by 32 until below 32
`timescale 1ns/10ps
module abou_unit
    import abou_pkg::*;
(
    // Clock and reset
    input  wire logic                   clk_in,
    input  wire logic                   rst_in,
    // Operation from the sequencer
    input  wire logic                   op_valid_in,
    input  wire abou_op_t               op_code_in,
    input  wire logic [ABOU_CNT_W-1:0]  op_count_in,
    input  wire logic [ABOU_ADDR_W-1:0] mem_addr_in,
    input  wire logic [31:0]            data_in,
    // Results and status
    output logic      [31:0]            acc_out,
    output logic      [ABOU_MEM_W-1:0]  mem_rdata_out,
    output logic                        zero_result_flag_out,
    output logic                        operand_error_flag_out,
    output logic                        done_out
);

    // All registered state of the unit except the word memory
    typedef struct packed {
        logic [31:0]           acc;
        logic [ABOU_MEM_W-1:0] rdata;
        logic                  zero_flag;
        logic                  err_flag;
        logic                  done;
    } abou_state_t;

    abou_state_t st_r;
    abou_state_t st_nxt;

    // Word memory; not reset, the sequencer loads it before use
    logic [ABOU_MEM_W-1:0] mem_q [ABOU_MEM_DEP];
    logic                  mem_we;
    logic [ABOU_MEM_W-1:0] mem_wdata;
    logic [ABOU_MEM_W-1:0] mem_word;
    logic [ABOU_MEM_W-1:0] mem_step;

    // Accumulator transform results
    logic [31:0] bit_result;
    logic        bit_error;

    abou_bitops abou_bitops_inst (
        .op_in      (op_code_in),
        .acc_in     (st_r.acc),
        .count_in   (op_count_in),
        .result_out (bit_result),
        .error_out  (bit_error)
    );

    // Read side of the read-modify-write is the addressed word itself
    assign mem_word = mem_q[mem_addr_in];

    // Plain 16-bit add and subtract wrap instead of saturating
    always_comb
    begin
        mem_step = mem_word;
        if (op_code_in == binary_increment_op)
        begin
            mem_step = mem_word + ABOU_MEM_ONE;
        end
        else if (op_code_in == binary_decrement_op)
        begin
            mem_step = mem_word - ABOU_MEM_ONE;
        end
    end

    // Next-state logic; every operation completes in one step
    always_comb
    begin
        st_nxt      = st_r;
        st_nxt.done = 1'b0;
        mem_we      = 1'b0;
        mem_wdata   = data_in[ABOU_MEM_W-1:0];
        if (op_valid_in)
        begin
            st_nxt.done = 1'b1;
            case (op_code_in)
                load_acc_op:
                begin
                    st_nxt.acc = data_in;
                end
                mem_write_op:
                begin
                    mem_we = 1'b1;
                end
                mem_read_op:
                begin
                    st_nxt.rdata = mem_word;
                end
                binary_increment_op, binary_decrement_op:
                begin
                    mem_we           = 1'b1;
                    mem_wdata        = mem_step;
                    st_nxt.zero_flag = (mem_step == ABOU_RDAT_RST);
                end
                bit_sum_op, shift_left_op, shift_right_op, rotate_left_op, rotate_right_op,
                decode_op:
                begin
                    st_nxt.acc = bit_result;
                end
                encode_op:
                begin
                    // Encode owns the error flag; a clean single bit clears it
                    st_nxt.acc      = bit_result;
                    st_nxt.err_flag = bit_error;
                end
                default:
                begin
                    st_nxt.done = 1'b1;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            st_r.acc       <= ABOU_ACC_RST;
            st_r.rdata     <= ABOU_RDAT_RST;
            st_r.zero_flag <= ABOU_FLAG_RST;
            st_r.err_flag  <= ABOU_FLAG_RST;
            st_r.done      <= ABOU_FLAG_RST;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // Memory write port
    always_ff @(posedge clk_in)
    begin
        if (mem_we)
        begin
            mem_q[mem_addr_in] <= mem_wdata;
        end
    end

    // Outputs straight from the state register
    assign acc_out                = st_r.acc;
    assign mem_rdata_out          = st_r.rdata;
    assign zero_result_flag_out   = st_r.zero_flag;
    assign operand_error_flag_out = st_r.err_flag;
    assign done_out               = st_r.done;

    // Helper decodes for the checks below
    logic take_inc;
    logic take_dec;
    logic take_cnt;

    assign take_inc = op_valid_in && (op_code_in == binary_increment_op);
    assign take_dec = op_valid_in && (op_code_in == binary_decrement_op);
    assign take_cnt = (op_count_in >= 6'h01) && (op_count_in <= ABOU_CNT_MAX);

    a_inc_write_back: assert property (
        @(posedge clk_in) disable iff (rst_in)
        take_inc |=> mem_q[$past(mem_addr_in)] == 16'($past(mem_word) + 16'h0001))
    else $error("increment did not write word plus one");

    a_dec_write_back: assert property (
        @(posedge clk_in) disable iff (rst_in)
        take_dec |=> mem_q[$past(mem_addr_in)] == 16'($past(mem_word) - 16'h0001))
    else $error("decrement did not write word minus one");

    a_zero_flag_set: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (take_inc || take_dec) |=>
            zero_result_flag_out == (mem_q[$past(mem_addr_in)] == 16'h0000))
    else $error("zero flag does not match written result");

    a_flag_hold: assert property (
        @(posedge clk_in) disable iff (rst_in)
        !(take_inc || take_dec) |=> $stable(zero_result_flag_out))
    else $error("zero flag changed without an affecting operation");

    a_err_hold: assert property (
        @(posedge clk_in) disable iff (rst_in)
        !(op_valid_in && op_code_in == encode_op) |=> $stable(operand_error_flag_out))
    else $error("error flag changed without an encode");

    a_bit_sum: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (op_valid_in && op_code_in == bit_sum_op) |=>
            acc_out == 32'($countones($past(acc_out))))
    else $error("bit sum result wrong");

    a_shift_left: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (op_valid_in && op_code_in == shift_left_op && take_cnt) |=>
            acc_out == ($past(acc_out) << $past(op_count_in)))
    else $error("shift left result wrong");

    a_shift_right: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (op_valid_in && op_code_in == shift_right_op && take_cnt) |=>
            acc_out == ($past(acc_out) >> $past(op_count_in)))
    else $error("shift right result wrong");

    a_rotate_left: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (op_valid_in && op_code_in == rotate_left_op && take_cnt) |=>
            acc_out == (({$past(acc_out), $past(acc_out)} << $past(op_count_in)) >> 32))
    else $error("rotate left result wrong");

    a_rotate_right: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (op_valid_in && op_code_in == rotate_right_op && take_cnt) |=>
            acc_out == 32'({$past(acc_out), $past(acc_out)} >> $past(op_count_in)))
    else $error("rotate right result wrong");

    a_encode_top: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (op_valid_in && op_code_in == encode_op && acc_out == 32'h8000_0000) |=>
            acc_out == 32'h0000_001f && !operand_error_flag_out)
    else $error("encode of top bit wrong");

    a_encode_small: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (op_valid_in && op_code_in == encode_op && acc_out <= 32'h0000_0001) |=>
            acc_out == 32'h0000_0000)
    else $error("encode of zero or one not zero");

    a_encode_multi: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (op_valid_in && op_code_in == encode_op && $countones(acc_out) > 1) |=>
            operand_error_flag_out && acc_out < 32'h0000_0020 &&
            ((($past(acc_out) >> acc_out[4:0]) & 32'h0000_0001) == 32'h0000_0001) &&
            (($past(acc_out) & ((32'h0000_0001 << acc_out[4:0]) - 32'h0000_0001))
             == 32'h0000_0000))
    else $error("encode of several bits wrong");

    a_encode_zero: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (op_valid_in && op_code_in == encode_op && acc_out == 32'h0000_0000) |=>
            operand_error_flag_out)
    else $error("encode of zero did not flag error");

    a_decode_small: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (op_valid_in && op_code_in == decode_op && acc_out < 32'h0000_0020) |=>
            acc_out == (32'h0000_0001 << $past(acc_out[4:0])))
    else $error("decode of small value wrong");

    a_decode_reduce: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (op_valid_in && op_code_in == decode_op && acc_out >= 32'h0000_0020 &&
         acc_out < 32'h0000_0400) |=>
            acc_out == (32'h0000_0001 << $past(acc_out[9:5])))
    else $error("decode of reduced value wrong");

    a_decode_onehot: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (op_valid_in && op_code_in == decode_op) |=> $onehot(acc_out))
    else $error("decode result not one-hot");

    a_inc_wrap: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (take_inc && mem_word == 16'hffff) |=>
            mem_q[$past(mem_addr_in)] == 16'h0000 && zero_result_flag_out)
    else $error("increment did not wrap");

    a_done_pulse: assert property (
        @(posedge clk_in) disable iff (rst_in)
        op_valid_in |=> done_out)
    else $error("operation not completed in one step");

    // Done stands the cycle after each op, high across back-to-back ops, never a level left over from an earlier op
    a_done_single: assert property (
        @(posedge clk_in) disable iff (rst_in)
        !op_valid_in |=> !done_out)
    else $error("done stood without an operation");

    // Underflow must wrap to all ones and leave the zero flag low
    a_dec_wrap: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (take_dec && mem_word == 16'h0000) |=>
            mem_q[$past(mem_addr_in)] == 16'hffff && !zero_result_flag_out)
    else $error("decrement did not wrap");

    // A lone bit zero is a clean operand: index zero and no error
    a_encode_one: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (op_valid_in && op_code_in == encode_op && acc_out == 32'h0000_0001) |=>
            acc_out == 32'h0000_0000 && !operand_error_flag_out)
    else $error("encode of one wrong");

    // Read data holds until the next memory read
    a_rdata_hold: assert property (
        @(posedge clk_in) disable iff (rst_in)
        !(op_valid_in && op_code_in == mem_read_op) |=> $stable(mem_rdata_out))
    else $error("read data changed without a read");

endmodule

/* test/abou_seq_model.sv */
// Sequencer model that issues operations to the unit one request at a time
`timescale 1ns/10ps
module abou_seq_model
    import abou_pkg::*;
(
    // Clock
    input  wire logic   clk_in,
    // Operation towards the unit
    output logic        op_valid_out,
    output abou_op_t    op_code_out,
    output logic [5:0]  op_count_out,
    output logic [5:0]  mem_addr_out,
    output logic [31:0] data_out,
    // Completion from the unit
    input  wire logic   done_in
);
    logic held_r;

    // Idle request at time zero
    initial
    begin
        held_r       = 1'b0;
        op_valid_out = 1'b0;
        op_code_out  = nop_op;
        op_count_out = 6'h00;
        mem_addr_out = 6'h00;
        data_out     = 32'h0000_0000;
    end

    // Drive after a falling edge, hold across the taking edge, sample done one cycle on.
    // With keep set the request stays up so the next call follows back to back.
    // Flags are never read here; the bench reads them before the next op that moves them.
    task automatic issue(input abou_op_t op, input logic [5:0] cnt, input logic [5:0] addr,
                         input logic [31:0] dat, input logic keep, output logic done);
    begin
        if (!held_r)
            @(negedge clk_in);
        op_valid_out = 1'b1;
        op_code_out  = op;
        op_count_out = cnt;
        mem_addr_out = addr;
        data_out     = dat;
        @(negedge clk_in);
        done   = done_in;
        held_r = keep;
        if (!keep)
        begin
            // Released fields show the inverse so a stale operand is never trusted
            op_valid_out = 1'b0;
            op_code_out  = ~op;
            op_count_out = ~cnt;
            mem_addr_out = ~addr;
            data_out     = ~dat;
        end
    end
    endtask
endmodule

/* test/abou_unit_test.sv */
// Self-checking bench for the accumulator bit-operation unit
`timescale 1ns/10ps
module abou_unit_test;
    import abou_pkg::*;

    logic        clk_in;
    logic        rst_in;
    logic        op_valid;
    abou_op_t    op_code;
    logic [5:0]  op_count;
    logic [5:0]  mem_addr;
    logic [31:0] data;
    logic [31:0] acc;
    logic [15:0] rdata;
    logic        zero_flag;
    logic        err_flag;
    logic        done;
    logic        got_done;
    int          fails;
    int          samples_checked;

    abou_unit abou_unit_inst (
        .clk_in                 (clk_in),
        .rst_in                 (rst_in),
        .op_valid_in            (op_valid),
        .op_code_in             (op_code),
        .op_count_in            (op_count),
        .mem_addr_in            (mem_addr),
        .data_in                (data),
        .acc_out                (acc),
        .mem_rdata_out          (rdata),
        .zero_result_flag_out   (zero_flag),
        .operand_error_flag_out (err_flag),
        .done_out               (done)
    );

    abou_seq_model abou_seq_model_inst (
        .clk_in       (clk_in),
        .op_valid_out (op_valid),
        .op_code_out  (op_code),
        .op_count_out (op_count),
        .mem_addr_out (mem_addr),
        .data_out     (data),
        .done_in      (done)
    );

    // Value comparison, counted and reported at once
    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    begin
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask

    // Flag comparison
    task automatic check_flag(input logic got, input logic exp);
    begin
        check_word({31'h0, got}, {31'h0, exp});
    end
    endtask

    // One whole operation with a gap after it; done must pulse one cycle on
    task automatic op(input abou_op_t c, input logic [5:0] n, input logic [5:0] a,
                      input logic [31:0] d);
    begin
        abou_seq_model_inst.issue(c, n, a, d, 1'b0, got_done);
        check_flag(got_done, 1'b1);
    end
    endtask

    // Verdict and end of run
    task automatic final_report;
    begin
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    end
    endtask

    // Outputs straight after reset
    task automatic t_reset;
    begin
        check_word(acc, 32'h0000_0000);
        check_word({16'h0000, rdata}, 32'h0000_0000);
        check_flag(zero_flag, 1'b0);
        check_flag(err_flag, 1'b0);
        check_flag(done, 1'b0);
    end
    endtask

    // Increment through the top of the word and on again
    task automatic t_inc_wrap;
    begin
        op(mem_write_op, 6'h00, 6'h05, 32'h0000_ffff);
        op(binary_increment_op, 6'h00, 6'h05, 32'h0000_0000);
        check_flag(zero_flag, 1'b1);
        op(mem_read_op, 6'h00, 6'h05, 32'h0000_0000);
        check_word({16'h0000, rdata}, 32'h0000_0000);
        op(binary_increment_op, 6'h00, 6'h05, 32'h0000_0000);
        check_flag(zero_flag, 1'b0);
        op(mem_read_op, 6'h00, 6'h05, 32'h0000_0000);
        check_word({16'h0000, rdata}, 32'h0000_0001);
    end
    endtask

    // Decrement below zero, then to zero; unrelated ops leave the zero flag alone
    task automatic t_dec_wrap;
    begin
        op(mem_write_op, 6'h00, 6'h3f, 32'h0000_0000);
        op(binary_decrement_op, 6'h00, 6'h3f, 32'h0000_0000);
        check_flag(zero_flag, 1'b0);
        op(mem_read_op, 6'h00, 6'h3f, 32'h0000_0000);
        check_word({16'h0000, rdata}, 32'h0000_ffff);
        op(mem_write_op, 6'h00, 6'h3f, 32'h0000_0001);
        op(binary_decrement_op, 6'h00, 6'h3f, 32'h0000_0000);
        check_flag(zero_flag, 1'b1);
        op(mem_read_op, 6'h00, 6'h3f, 32'h0000_0000);
        check_word({16'h0000, rdata}, 32'h0000_0000);
        op(load_acc_op, 6'h00, 6'h00, 32'h0000_0006);
        op(encode_op, 6'h00, 6'h00, 32'h0000_0000);
        check_flag(err_flag, 1'b1);
        op(bit_sum_op, 6'h00, 6'h00, 32'h0000_0000);
        op(nop_op, 6'h00, 6'h00, 32'h0000_0000);
        check_word(acc, 32'h0000_0001);
        check_flag(zero_flag, 1'b1);
        check_flag(err_flag, 1'b1);
    end
    endtask

    // Ones count over sparse and full patterns
    task automatic t_bit_sum;
        logic [31:0] vals [4];
    begin
        vals = '{32'h0000_0000, 32'hffff_ffff, 32'h8000_0001, 32'h0f0f_00f0};
        foreach (vals[i])
        begin
            op(load_acc_op, 6'h00, 6'h00, vals[i]);
            op(bit_sum_op, 6'h00, 6'h00, 32'h0000_0000);
            check_word(acc, 32'($countones(vals[i])));
        end
    end
    endtask

    // Every shift and rotate at the count boundaries
    task automatic t_move;
        abou_op_t    codes [4];
        logic [5:0]  cnts [4];
        logic [31:0] v;
        logic [63:0] w;
        logic [31:0] e;
    begin
        codes = '{shift_left_op, shift_right_op, rotate_left_op, rotate_right_op};
        cnts  = '{6'h01, 6'h02, 6'h1f, 6'h20};
        v     = 32'h8c31_0f5a;
        foreach (codes[i])
        begin
            foreach (cnts[j])
            begin
                w = ({v, v} << cnts[j]);
                case (i)
                    0: e = v << cnts[j];
                    1: e = v >> cnts[j];
                    2: e = w[63:32];
                    default: e = 32'(({v, v} >> cnts[j]));
                endcase
                op(load_acc_op, 6'h00, 6'h00, v);
                op(codes[i], cnts[j], 6'h00, 32'h0000_0000);
                check_word(acc, e);
            end
        end
    end
    endtask

    // Encode of single, multiple, zero and one
    task automatic t_encode;
        logic [31:0] vals [5];
        logic [31:0] idx [5];
        logic        errs [5];
    begin
        vals = '{32'h8000_0000, 32'h0000_0001, 32'h0000_0000, 32'h0000_0c00, 32'h0000_0010};
        idx  = '{32'h0000_001f, 32'h0000_0000, 32'h0000_0000, 32'h0000_000a, 32'h0000_0004};
        errs = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
        foreach (vals[i])
        begin
            op(load_acc_op, 6'h00, 6'h00, vals[i]);
            op(encode_op, 6'h00, 6'h00, 32'h0000_0000);
            check_word(acc, idx[i]);
            check_flag(err_flag, errs[i]);
        end
    end
    endtask

    // Decode with in-range and repeatedly reduced values
    task automatic t_decode;
        logic [31:0] vals [5];
        logic [31:0] r;
    begin
        vals = '{32'h0000_000f, 32'h0000_001f, 32'h0000_0021, 32'h0000_0400, 32'hffff_ffff};
        foreach (vals[i])
        begin
            r = vals[i];
            while (r >= 32'h0000_0020)
                r = r / 32'h0000_0020;
            op(load_acc_op, 6'h00, 6'h00, vals[i]);
            op(decode_op, 6'h00, 6'h00, 32'h0000_0000);
            check_word(acc, 32'h0000_0001 << r[4:0]);
        end
    end
    endtask

    // Load then encode on consecutive edges; encode must see the fresh value
    task automatic t_back_to_back;
    begin
        abou_seq_model_inst.issue(load_acc_op, 6'h00, 6'h00, 32'h0000_4000, 1'b1, got_done);
        check_word(acc, 32'h0000_4000);
        abou_seq_model_inst.issue(encode_op, 6'h00, 6'h00, 32'h0000_0000, 1'b0, got_done);
        check_flag(got_done, 1'b1);
        check_word(acc, 32'h0000_000e);
        check_flag(err_flag, 1'b0);
    end
    endtask

    // Free-running clock
    initial
    begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end

    // Hang guard, well beyond the roughly 160 cycles the scenarios need
    initial
    begin
        #100000;
        fails++;
        final_report();
    end

    // Main sequence
    initial
    begin
        fails           = 0;
        samples_checked = 0;
        rst_in          = 1'b1;
        repeat (5) @(negedge clk_in);
        rst_in = 1'b0;
        t_reset();
        t_inc_wrap();
        t_dec_wrap();
        t_bit_sum();
        t_move();
        t_encode();
        t_decode();
        t_back_to_back();
        final_report();
    end
endmodule
